// [core/ufp_map.svh]
`ifndef UFP_MAP_SVH
`define UFP_MAP_SVH

// Boot-ROM entry points selected by the call target operand.
`define UFP_ENTRY_PAGE_ERASE  8'h17
`define UFP_ENTRY_MASS_ERASE  8'h1a
`define UFP_ENTRY_READ_BYTE   8'h11
`define UFP_ENTRY_WRITE_BYTE  8'h14
`define UFP_ENTRY_BLOCK_READ  8'h26
`define UFP_ENTRY_BLOCK_WRITE 8'h23
`define UFP_ENTRY_EXIT        8'h62
`define UFP_ENTRY_SERIAL_ISP  8'h00

// Key values.
`define UFP_UNLOCK_KEY        8'h98
`define UFP_MASS_CONFIRM_KEY  8'h55

// Largest block write count.
`define UFP_BLOCK_WRITE_MAX   8'h10

// Instruction cycles for which the unlock key stays valid.
`define UFP_KEY_WINDOW_CYCLES 3'h6

// Reset values.
`define UFP_BYTE_RESET        8'h00
`define UFP_ADDR_RESET        16'h0000

`endif

// [core/ufp_pkg.sv]
package ufp_pkg;

  typedef enum logic [6:0] {
    UFP_S_IDLE   = 7'b0000001,
    UFP_S_FLASH  = 7'b0000010,
    UFP_S_RAM_WR = 7'b0000100,
    UFP_S_RAM_RD = 7'b0001000,
    UFP_S_DONE   = 7'b0010000,
    UFP_S_ISP    = 7'b0100000,
    UFP_S_RST    = 7'b1000000
  } ufp_state_e;

  typedef enum logic [1:0] {
    UFP_FC_READ       = 2'h0,
    UFP_FC_WRITE      = 2'h1,
    UFP_FC_PAGE_ERASE = 2'h2,
    UFP_FC_MASS_ERASE = 2'h3
  } ufp_fcmd_e;

  typedef logic [7:0] ufp_byte_t;

endpackage : ufp_pkg

// [core/ufp_key_window.sv]
`timescale 1ns/1ps
`include "ufp_map.svh"

module ufp_key_window (
  input  logic           clk,
  input  logic           reset_n,
  input  logic           key_write,
  input  ufp_pkg::ufp_byte_t key_data,
  input  logic           consume,
  output logic           key_valid
);
  import ufp_pkg::*;

  logic [2:0] left_reg;

  // The key arms a short window; any other key value or a call closes it.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      left_reg <= 3'h0;
    end else if (key_write) begin
      left_reg <= (key_data == `UFP_UNLOCK_KEY) ? `UFP_KEY_WINDOW_CYCLES : 3'h0;
    end else if (consume) begin
      left_reg <= 3'h0;
    end else if (left_reg != 3'h0) begin
      left_reg <= left_reg - 3'h1;
    end
  end

  assign key_valid = (left_reg != 3'h0);

endmodule : ufp_key_window

// [core/ufp_block_counter.sv]
`timescale 1ns/1ps
`include "ufp_map.svh"

module ufp_block_counter (
  input  logic               clk,
  input  logic               reset_n,
  input  logic               load,
  input  ufp_pkg::ufp_byte_t load_value,
  input  logic               step,
  output ufp_pkg::ufp_byte_t count,
  output logic               last
);
  import ufp_pkg::*;

  ufp_byte_t count_reg;

  // Counts the bytes that remain in a block transfer.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= `UFP_BYTE_RESET;
    end else if (load) begin
      count_reg <= load_value;
    end else if (step && (count_reg != 8'h00)) begin
      count_reg <= count_reg - 8'h01;
    end
  end

  assign count = count_reg;
  assign last  = (count_reg == 8'h01);

endmodule : ufp_block_counter

// [core/ufp_user_flash_program_entry.sv]
`timescale 1ns/1ps
`include "ufp_map.svh"

// Operation
// R01: Caller picks the operation by the entry value given to the boot ROM call.
// R02: Entry 0x17 erases the flash page at the high and low address bytes.
// R03: Caller loads high and low address bytes before any addressed operation.
// R04: Entry 0x1A erases all flash, only with 0x55 in the accumulator.
// R05: After a mass erase the device enters serial programming mode, no return.
// R06: Entry 0x11 reads one flash byte into the read result location.
// R07: Entry 0x14 programs the write data byte at the supplied address.
// R08: Entry 0x26 reads n flash bytes, n from 0 to 255.
// R09: Block read bytes go to successive RAM locations from the index pointer.
// R10: Entry 0x23 programs n flash bytes, n from 0 to 16.
// R11: Caller keeps a block write inside one 64-byte boundary.
// R12: Block write takes bytes from successive RAM locations from the index pointer.
// R13: Caller sets the RAM segment so the index pointer hits the wanted area.
// R14: Entry 0x62 resets the device instead of returning.
// R15: Entry 0x00 enters serial programming mode until a serial exit resets.
// R16: No security check here; calling firmware enforces its own protection.
// R17: A call counts only if key 0x98 was written within six cycles before.
// R18: Caller loads the write timing register before any write or erase.
// R19: Interrupts are blocked during an operation; the global enable is untouched.
// R20: Other operations resume at the instruction after the call.
module ufp_user_flash_program_entry (
  input  logic                clk,
  input  logic                reset_n,
  input  logic                boot_rom_call,
  input  ufp_pkg::ufp_byte_t  call_entry,
  input  ufp_pkg::ufp_byte_t  accumulator,
  input  logic                key_write,
  input  ufp_pkg::ufp_byte_t  unlock_key_reg,
  input  ufp_pkg::ufp_byte_t  flash_addr_high,
  input  ufp_pkg::ufp_byte_t  flash_addr_low,
  input  ufp_pkg::ufp_byte_t  write_data_holder,
  input  ufp_pkg::ufp_byte_t  block_byte_count,
  input  ufp_pkg::ufp_byte_t  index_ptr,
  input  ufp_pkg::ufp_byte_t  ram_segment,
  input  logic                flash_ack,
  input  ufp_pkg::ufp_byte_t  flash_rdata,
  input  logic                ram_ack,
  input  ufp_pkg::ufp_byte_t  ram_rdata,
  output logic                flash_req,
  output ufp_pkg::ufp_fcmd_e  flash_cmd,
  output logic [15:0]         flash_addr,
  output ufp_pkg::ufp_byte_t  flash_wdata,
  output logic                ram_req,
  output logic                ram_we,
  output logic [15:0]         ram_addr,
  output ufp_pkg::ufp_byte_t  ram_wdata,
  output ufp_pkg::ufp_byte_t  read_result,
  output logic                busy,
  output logic                irq_block,
  output logic                call_return,
  output logic                call_rejected,
  output logic                isp_mode,
  output logic                device_reset_req
);
  import ufp_pkg::*;

  ufp_state_e state_reg;
  ufp_state_e state_next;
  ufp_byte_t  op_reg;
  logic       key_ok;
  logic       call_ok;
  logic       step;
  logic       cnt_last;
  ufp_byte_t  cnt_value;

  logic       flash_req_reg;
  ufp_fcmd_e  flash_cmd_reg;
  logic [15:0] flash_addr_reg;
  ufp_byte_t  flash_wdata_reg;
  logic       ram_req_reg;
  logic       ram_we_reg;
  logic [15:0] ram_addr_reg;
  ufp_byte_t  ram_wdata_reg;
  ufp_byte_t  read_result_reg;
  logic       busy_reg;
  logic       irq_block_reg;
  logic       call_return_reg;
  logic       call_rejected_reg;
  logic       isp_mode_reg;
  logic       reset_req_reg;

  // A call is taken only when idle and the unlock window is still open.
  assign call_ok = boot_rom_call && key_ok && (state_reg == UFP_S_IDLE); // R17

  ufp_key_window u_key (
    .clk       (clk),
    .reset_n   (reset_n),
    .key_write (key_write),
    .key_data  (unlock_key_reg),
    .consume   (boot_rom_call),
    .key_valid (key_ok)
  );

  // One byte of a block is finished when its second half of the transfer is acknowledged.
  assign step = ((state_reg == UFP_S_RAM_WR) && ram_ack) ||
                ((state_reg == UFP_S_FLASH) && flash_ack && (op_reg == `UFP_ENTRY_BLOCK_WRITE));

  ufp_block_counter u_cnt (
    .clk        (clk),
    .reset_n    (reset_n),
    .load       (call_ok),
    .load_value (block_byte_count),
    .step       (step),
    .count      (cnt_value),
    .last       (cnt_last)
  );

  // Sequencing of each entry point.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      UFP_S_IDLE: begin
        if (call_ok) begin
          if (call_entry == `UFP_ENTRY_PAGE_ERASE) begin
            state_next = UFP_S_FLASH; // R02
          end else if (call_entry == `UFP_ENTRY_MASS_ERASE) begin
            state_next = (accumulator == `UFP_MASS_CONFIRM_KEY) ? UFP_S_FLASH : UFP_S_DONE; // R04
          end else if ((call_entry == `UFP_ENTRY_READ_BYTE) ||
                       (call_entry == `UFP_ENTRY_WRITE_BYTE)) begin
            state_next = UFP_S_FLASH; // R06 R07
          end else if (call_entry == `UFP_ENTRY_BLOCK_READ) begin
            state_next = (block_byte_count == 8'h00) ? UFP_S_DONE : UFP_S_FLASH; // R08
          end else if (call_entry == `UFP_ENTRY_BLOCK_WRITE) begin
            state_next = ((block_byte_count == 8'h00) ||
                          (block_byte_count > `UFP_BLOCK_WRITE_MAX)) ?
                         UFP_S_DONE : UFP_S_RAM_RD; // R10
          end else if (call_entry == `UFP_ENTRY_EXIT) begin
            state_next = UFP_S_RST; // R14
          end else if (call_entry == `UFP_ENTRY_SERIAL_ISP) begin
            state_next = UFP_S_ISP; // R15
          end else begin
            state_next = UFP_S_DONE;
          end
        end
      end
      UFP_S_FLASH: begin
        if (flash_ack) begin
          if (op_reg == `UFP_ENTRY_MASS_ERASE) begin
            state_next = UFP_S_ISP; // R05
          end else if (op_reg == `UFP_ENTRY_BLOCK_READ) begin
            state_next = UFP_S_RAM_WR; // R09
          end else if ((op_reg == `UFP_ENTRY_BLOCK_WRITE) && !cnt_last) begin
            state_next = UFP_S_RAM_RD; // R12
          end else begin
            state_next = UFP_S_DONE;
          end
        end
      end
      UFP_S_RAM_WR: begin
        if (ram_ack) begin
          state_next = cnt_last ? UFP_S_DONE : UFP_S_FLASH; // R08
        end
      end
      UFP_S_RAM_RD: begin
        if (ram_ack) begin
          state_next = UFP_S_FLASH;
        end
      end
      UFP_S_DONE: begin
        state_next = UFP_S_IDLE; // R20
      end
      UFP_S_ISP: begin
        state_next = UFP_S_ISP; // R15
      end
      UFP_S_RST: begin
        state_next = UFP_S_RST;
      end
      default: begin
        state_next = UFP_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= UFP_S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Operation and flash command captured at the call.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op_reg        <= `UFP_BYTE_RESET;
      flash_cmd_reg <= UFP_FC_READ;
    end else if (call_ok) begin
      op_reg <= call_entry;
      if (call_entry == `UFP_ENTRY_PAGE_ERASE) begin
        flash_cmd_reg <= UFP_FC_PAGE_ERASE; // R02
      end else if (call_entry == `UFP_ENTRY_MASS_ERASE) begin
        flash_cmd_reg <= UFP_FC_MASS_ERASE; // R04
      end else if ((call_entry == `UFP_ENTRY_WRITE_BYTE) ||
                   (call_entry == `UFP_ENTRY_BLOCK_WRITE)) begin
        flash_cmd_reg <= UFP_FC_WRITE; // R07
      end else begin
        flash_cmd_reg <= UFP_FC_READ; // R06
      end
    end
  end

  // Flash address from the two address bytes, stepping through a block.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_addr_reg <= `UFP_ADDR_RESET;
    end else if (call_ok) begin
      flash_addr_reg <= {flash_addr_high, flash_addr_low}; // R03
    end else if (step) begin
      flash_addr_reg <= flash_addr_reg + 16'h0001;
    end
  end

  // RAM address from segment and index pointer, one location per byte.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ram_addr_reg <= `UFP_ADDR_RESET;
    end else if (call_ok) begin
      ram_addr_reg <= {ram_segment, index_ptr}; // R09 R12
    end else if (((state_reg == UFP_S_RAM_WR) || (state_reg == UFP_S_RAM_RD)) && ram_ack) begin
      ram_addr_reg <= ram_addr_reg + 16'h0001; // R09 R12
    end
  end

  // Data paths between the two sides.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_wdata_reg <= `UFP_BYTE_RESET;
    end else if (call_ok) begin
      flash_wdata_reg <= write_data_holder; // R07
    end else if ((state_reg == UFP_S_RAM_RD) && ram_ack) begin
      flash_wdata_reg <= ram_rdata; // R12
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ram_wdata_reg <= `UFP_BYTE_RESET;
    end else if ((state_reg == UFP_S_FLASH) && flash_ack &&
                 (op_reg == `UFP_ENTRY_BLOCK_READ)) begin
      ram_wdata_reg <= flash_rdata; // R09
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      read_result_reg <= `UFP_BYTE_RESET;
    end else if ((state_reg == UFP_S_FLASH) && flash_ack && (op_reg == `UFP_ENTRY_READ_BYTE)) begin
      read_result_reg <= flash_rdata; // R06
    end
  end

  // Handshake and status outputs, registered from the next state except call_rejected, which comes from the current state.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_req_reg     <= 1'b0;
      ram_req_reg       <= 1'b0;
      ram_we_reg        <= 1'b0;
      busy_reg          <= 1'b0;
      irq_block_reg     <= 1'b0;
      call_return_reg   <= 1'b0;
      call_rejected_reg <= 1'b0;
      isp_mode_reg      <= 1'b0;
      reset_req_reg     <= 1'b0;
    end else begin
      flash_req_reg     <= (state_next == UFP_S_FLASH);
      ram_req_reg       <= (state_next == UFP_S_RAM_WR) || (state_next == UFP_S_RAM_RD);
      ram_we_reg        <= (state_next == UFP_S_RAM_WR);
      busy_reg          <= (state_next != UFP_S_IDLE);
      irq_block_reg     <= (state_next != UFP_S_IDLE); // R19
      call_return_reg   <= (state_next == UFP_S_DONE); // R20
      call_rejected_reg <= boot_rom_call && !key_ok && (state_reg == UFP_S_IDLE); // R17
      isp_mode_reg      <= (state_next == UFP_S_ISP); // R05 R15
      reset_req_reg     <= (state_next == UFP_S_RST); // R14
    end
  end

  assign flash_req        = flash_req_reg;
  assign flash_cmd        = flash_cmd_reg;
  assign flash_addr       = flash_addr_reg;
  assign flash_wdata      = flash_wdata_reg;
  assign ram_req          = ram_req_reg;
  assign ram_we           = ram_we_reg;
  assign ram_addr         = ram_addr_reg;
  assign ram_wdata        = ram_wdata_reg;
  assign read_result      = read_result_reg;
  assign busy             = busy_reg;
  assign irq_block        = irq_block_reg;
  assign call_return      = call_return_reg;
  assign call_rejected    = call_rejected_reg;
  assign isp_mode         = isp_mode_reg;
  assign device_reset_req = reset_req_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_call(logic [7:0] e);
    call_ok && (call_entry == e);
  endsequence

  sequence s_flash_done(logic [7:0] e);
    (state_reg == UFP_S_FLASH) && flash_ack && (op_reg == e);
  endsequence

  AST_KEY_REJECT: assert property ( // R17
    (boot_rom_call && !key_ok && (state_reg == UFP_S_IDLE)) |=>
      call_rejected && (state_reg == UFP_S_IDLE))
    else $error("Call without key was not rejected.");

  AST_PAGE_ERASE: assert property ( // R02
    s_call(`UFP_ENTRY_PAGE_ERASE) |=> flash_req && (flash_cmd == UFP_FC_PAGE_ERASE) &&
      (flash_addr == {$past(flash_addr_high), $past(flash_addr_low)}))
    else $error("Page erase not issued at the given address.");

  AST_MASS_KEY: assert property ( // R04
    (s_call(`UFP_ENTRY_MASS_ERASE) ##0 (accumulator != `UFP_MASS_CONFIRM_KEY)) |=>
      !flash_req && call_return)
    else $error("Mass erase started without the confirmation key.");

  AST_MASS_ISP: assert property ( // R05
    s_flash_done(`UFP_ENTRY_MASS_ERASE) |=> (isp_mode && !call_return)[*3])
    else $error("Mass erase did not enter serial programming mode.");

  AST_READ_RESULT: assert property ( // R06
    s_flash_done(`UFP_ENTRY_READ_BYTE) |=>
      (read_result == $past(flash_rdata)) && call_return ##1 !busy)
    else $error("Read byte result or return wrong.");

  AST_WRITE_DATA: assert property ( // R07
    s_call(`UFP_ENTRY_WRITE_BYTE) |=> flash_req && (flash_cmd == UFP_FC_WRITE) &&
      (flash_wdata == $past(write_data_holder)))
    else $error("Write byte not issued with the held data.");

  AST_BR_STORE: assert property ( // R09
    s_flash_done(`UFP_ENTRY_BLOCK_READ) |=> ram_req && ram_we &&
      (ram_wdata == $past(flash_rdata)) && (ram_addr == $past(ram_addr)))
    else $error("Block read byte not stored to RAM.");

  AST_BR_COUNT: assert property ( // R08
    (s_call(`UFP_ENTRY_BLOCK_READ) ##0 (block_byte_count != 8'h00)) |=>
      flash_req && (cnt_value == $past(block_byte_count)))
    else $error("Block read count not loaded at the call.");

  AST_BW_FETCH: assert property ( // R12
    ((state_reg == UFP_S_RAM_RD) && ram_ack) |=> flash_req &&
      (flash_wdata == $past(ram_rdata)) && (ram_addr == $past(ram_addr) + 16'h0001))
    else $error("Block write byte not taken from RAM.");

  AST_BW_LIMIT: assert property ( // R10
    (s_call(`UFP_ENTRY_BLOCK_WRITE) ##0 (block_byte_count > `UFP_BLOCK_WRITE_MAX)) |=>
      call_return && !ram_req)
    else $error("Oversized block write was started.");

  AST_EXIT_RESET: assert property ( // R14
    s_call(`UFP_ENTRY_EXIT) |=> (device_reset_req && !call_return)[*4])
    else $error("Exit entry did not request a reset.");

  AST_ISP_HOLD: assert property ( // R15
    isp_mode |=> isp_mode && busy && !call_return)
    else $error("Serial programming mode was left.");

  AST_IRQ_BLOCK: assert property ( // R19
    irq_block == (state_reg != UFP_S_IDLE))
    else $error("Interrupts not blocked during an operation.");

endmodule : ufp_user_flash_program_entry

// [test/ufp_mem_model.sv]
`timescale 1ns/1ps

module ufp_mem_model
  import ufp_pkg::*;
#(
  parameter int PAGE_BYTES = 128
) (
  input  logic        clk,
  input  logic        reset_n,
  input  logic        slow,
  input  logic        flash_req,
  input  ufp_fcmd_e   flash_cmd,
  input  logic [15:0] flash_addr,
  input  ufp_byte_t   flash_wdata,
  output logic        flash_ack,
  output ufp_byte_t   flash_rdata,
  input  logic        ram_req,
  input  logic        ram_we,
  input  logic [15:0] ram_addr,
  input  ufp_byte_t   ram_wdata,
  output logic        ram_ack,
  output ufp_byte_t   ram_rdata
);
  logic [7:0] fmem [65536];
  logic [7:0] rmem [65536];
  logic [2:0] fcnt;
  logic [2:0] rcnt;
  logic [2:0] delay;
  logic [15:0] base;

  assign delay = slow ? 3'h3 : 3'h0;

  initial begin
    for (int a = 0; a < 65536; a++) begin
      fmem[a] = a[7:0] ^ a[15:8];
      rmem[a] = a[7:0] + 8'h33;
    end
  end

  // Flash side answers one byte per request; data turns over when idle.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_ack <= 1'b0;
      fcnt <= 3'h0;
      flash_rdata <= 8'h00;
    end else if (flash_ack) begin
      flash_ack <= 1'b0;
      fcnt <= 3'h0;
      flash_rdata <= ~flash_rdata;
    end else if (flash_req && fcnt >= delay) begin
      flash_ack <= 1'b1;
      flash_rdata <= fmem[flash_addr];
      base = flash_addr & ~16'(PAGE_BYTES - 1);
      case (flash_cmd)
        UFP_FC_WRITE: fmem[flash_addr] = flash_wdata;
        UFP_FC_PAGE_ERASE: for (int i = 0; i < PAGE_BYTES; i++) fmem[base + 16'(i)] = 8'hff;
        UFP_FC_MASS_ERASE: for (int i = 0; i < 65536; i++) fmem[i] = 8'hff;
        default: ;
      endcase
    end else begin
      fcnt <= fcnt + 3'(flash_req);
      flash_rdata <= ~flash_rdata;
    end
  end

  // RAM side uses the same single-cycle acknowledge.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ram_ack <= 1'b0;
      rcnt <= 3'h0;
      ram_rdata <= 8'h00;
    end else if (ram_ack) begin
      ram_ack <= 1'b0;
      rcnt <= 3'h0;
      ram_rdata <= ~ram_rdata;
    end else if (ram_req && rcnt >= delay) begin
      ram_ack <= 1'b1;
      ram_rdata <= rmem[ram_addr];
      if (ram_we) rmem[ram_addr] = ram_wdata;
    end else begin
      rcnt <= rcnt + 3'(ram_req);
      ram_rdata <= ~ram_rdata;
    end
  end
endmodule : ufp_mem_model

// [test/ufp_user_flash_program_entry_tb.sv]
`timescale 1ns/1ps
`include "ufp_map.svh"

module ufp_user_flash_program_entry_tb;
  import ufp_pkg::*;
  logic        clk, reset_n, boot_rom_call, key_write, flash_ack, ram_ack, slow;
  ufp_byte_t   call_entry, accumulator, unlock_key_reg, flash_addr_high, flash_addr_low;
  ufp_byte_t   write_data_holder, block_byte_count, index_ptr, ram_segment;
  ufp_byte_t   flash_rdata, ram_rdata, flash_wdata, ram_wdata, read_result, wd;
  logic        flash_req, ram_req, ram_we, busy, irq_block, call_return, call_rejected;
  logic        isp_mode, device_reset_req, isp_prev, rst_prev;
  ufp_fcmd_e   flash_cmd;
  logic [15:0] flash_addr, ram_addr, fa, ra;
  logic [27:0] expq [$];
  int          err_count, num_checks, cycles;
  integer      seed;

  ufp_user_flash_program_entry ufp_user_flash_program_entry_inst (
    .clk, .reset_n, .boot_rom_call, .call_entry, .accumulator, .key_write, .unlock_key_reg,
    .flash_addr_high, .flash_addr_low, .write_data_holder, .block_byte_count, .index_ptr,
    .ram_segment, .flash_ack, .flash_rdata, .ram_ack, .ram_rdata, .flash_req, .flash_cmd,
    .flash_addr, .flash_wdata, .ram_req, .ram_we, .ram_addr, .ram_wdata, .read_result,
    .busy, .irq_block, .call_return, .call_rejected, .isp_mode, .device_reset_req);

  ufp_mem_model ufp_mem_model_inst (
    .clk, .reset_n, .slow, .flash_req, .flash_cmd, .flash_addr, .flash_wdata, .flash_ack,
    .flash_rdata, .ram_req, .ram_we, .ram_addr, .ram_wdata, .ram_ack, .ram_rdata);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task check(input logic [27:0] seen, input logic [27:0] expv);
    num_checks++;
    if (seen !== expv) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task wrap_up;
    if (err_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  task note(input logic [3:0] k, input logic [15:0] a, input logic [7:0] d);
    expq.push_back({k, a, d});
  endtask : note

  task obs(input logic [3:0] k, input logic [15:0] a, input logic [7:0] d);
    if (expq.size() == 0) check({k, a, d}, 28'hfffffff);
    else check({k, a, d}, expq.pop_front());
  endtask : obs

  // Key write, then the call after gap cycles, then wait out the operation.
  task op(input ufp_byte_t entry, input ufp_byte_t acc, input int gap, input int bound);
    @(posedge clk); #1;
    key_write = 1'b1;
    unlock_key_reg = `UFP_UNLOCK_KEY;
    call_entry = entry;
    accumulator = acc;
    slow = 1'($random(seed));
    @(posedge clk); #1;
    key_write = 1'b0;
    unlock_key_reg = 8'($random(seed));
    repeat (gap - 1) @(posedge clk);
    #1;
    boot_rom_call = 1'b1;
    @(posedge clk); #1;
    boot_rom_call = 1'b0;
    for (int i = 0; i < bound && busy === 1'b1; i++) begin
      check({27'h0, irq_block}, 28'h1);
      @(posedge clk); #1;
    end
  endtask : op

  task pulse_reset;
    @(posedge clk); #1;
    reset_n = 1'b0;
    @(posedge clk); #1;
    reset_n = 1'b1;
  endtask : pulse_reset

  // Watches the outputs and compares each result with the oldest note.
  always @(posedge clk) begin
    if (reset_n) begin
      if (flash_req && flash_ack)
        obs({2'h0, flash_cmd}, flash_cmd == UFP_FC_MASS_ERASE ? 16'h0 : flash_addr,
            flash_cmd == UFP_FC_WRITE ? flash_wdata : 8'h00);
      if (ram_req && ram_ack) obs(ram_we ? 4'h4 : 4'h5, ram_addr, ram_we ? ram_wdata : 8'h00);
      if (call_return) obs(4'h6, 16'h0, 8'h00);
      if (call_rejected) obs(4'h7, 16'h0, 8'h00);
      if (isp_mode && !isp_prev) obs(4'h8, 16'h0, 8'h00);
      if (device_reset_req && !rst_prev) obs(4'h9, 16'h0, 8'h00);
    end
    isp_prev = isp_mode;
    rst_prev = device_reset_req;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles >= 20000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    seed = 32'hcb19;
    {reset_n, boot_rom_call, key_write, slow, call_entry, accumulator, unlock_key_reg} = '0;
    {flash_addr_high, flash_addr_low, write_data_holder, block_byte_count} = '0;
    {index_ptr, ram_segment, isp_prev, rst_prev} = '0;
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    check({21'h0, busy, irq_block, isp_mode, device_reset_req, flash_req, ram_req, call_return},
          28'h0);
    note(4'h7, 16'h0, 8'h00);
    op(`UFP_ENTRY_READ_BYTE, 8'h00, 7, 5);
    for (int i = 1; i <= 6; i++) begin
      fa = 16'($random(seed));
      {flash_addr_high, flash_addr_low} = fa;
      note(4'h0, fa, 8'h00);
      note(4'h6, 16'h0, 8'h00);
      op(`UFP_ENTRY_READ_BYTE, 8'($random(seed)), i, 40);
      check({20'h0, read_result}, {20'h0, fa[7:0] ^ fa[15:8]});
    end
    wd = 8'($random(seed));
    {flash_addr_high, flash_addr_low, write_data_holder} = {16'h4a21, wd};
    note(4'h1, 16'h4a21, wd);
    note(4'h6, 16'h0, 8'h00);
    op(`UFP_ENTRY_WRITE_BYTE, 8'h00, 2, 40);
    note(4'h0, 16'h4a21, 8'h00);
    note(4'h6, 16'h0, 8'h00);
    op(`UFP_ENTRY_READ_BYTE, 8'h00, 3, 40);
    check({20'h0, read_result}, {20'h0, wd});
    {flash_addr_high, flash_addr_low} = 16'h3c80;
    note(4'h2, 16'h3c80, 8'h00);
    note(4'h6, 16'h0, 8'h00);
    op(`UFP_ENTRY_PAGE_ERASE, 8'h00, 4, 40);
    for (int j = 0; j < 3; j++) begin
      block_byte_count = j == 0 ? 8'd0 : (j == 1 ? 8'd3 : 8'd255);
      {flash_addr_high, flash_addr_low} = 16'h20f0 + 16'(j * 256);
      {ram_segment, index_ptr} = {8'h05 + 8'(j), 8'h10 + 8'(j)};
      for (int i = 0; i < block_byte_count; i++) begin
        fa = {flash_addr_high, flash_addr_low} + 16'(i);
        note(4'h0, fa, 8'h00);
        note(4'h4, {ram_segment, index_ptr} + 16'(i), fa[7:0] ^ fa[15:8]);
      end
      note(4'h6, 16'h0, 8'h00);
      op(`UFP_ENTRY_BLOCK_READ, 8'h00, 5, 4000);
    end
    // Destination stays inside one 64-byte span and the segment is set first.
    for (int j = 0; j < 3; j++) begin
      block_byte_count = j == 0 ? 8'd16 : (j == 1 ? 8'd17 : 8'd0);
      {flash_addr_high, flash_addr_low} = 16'h7040;
      {ram_segment, index_ptr} = {8'h09, 8'($random(seed))};
      for (int i = 0; i < block_byte_count && block_byte_count <= 8'd16; i++) begin
        ra = {ram_segment, index_ptr} + 16'(i);
        note(4'h5, ra, 8'h00);
        note(4'h1, 16'h7040 + 16'(i), ra[7:0] + 8'h33);
      end
      note(4'h6, 16'h0, 8'h00);
      op(`UFP_ENTRY_BLOCK_WRITE, 8'h00, 6, 600);
    end
    note(4'h6, 16'h0, 8'h00);
    op(8'h99, 8'h00, 1, 40);
    note(4'h6, 16'h0, 8'h00);
    op(`UFP_ENTRY_MASS_ERASE, 8'h54, 2, 40);
    note(4'h9, 16'h0, 8'h00);
    op(`UFP_ENTRY_EXIT, 8'h00, 2, 10);
    pulse_reset();
    note(4'h8, 16'h0, 8'h00);
    op(`UFP_ENTRY_SERIAL_ISP, 8'h00, 3, 10);
    check({27'h0, isp_mode}, 28'h1);
    pulse_reset();
    note(4'h3, 16'h0, 8'h00);
    note(4'h8, 16'h0, 8'h00);
    op(`UFP_ENTRY_MASS_ERASE, `UFP_MASS_CONFIRM_KEY, 4, 40);
    check({27'h0, isp_mode}, 28'h1);
    repeat (4) @(posedge clk);
    check(28'(expq.size()), 28'h0);
    wrap_up();
  end
endmodule : ufp_user_flash_program_entry_tb
